// File: src/pdcb_params.svh
/*
  Offsets, field positions and reset values of the divider configuration bank.
  Assumes inclusion by bare name from the bank's design files.
*/
`ifndef PDCB_PARAMS_SVH
`define PDCB_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PDCB_OFF_OUT_MID   8'h20
`define PDCB_OFF_OUT_LOW   8'h21
`define PDCB_OFF_FB_TOP    8'h28
`define PDCB_OFF_FB_MID    8'h29
`define PDCB_OFF_FB_LOW    8'h2a
`define PDCB_OFF_IN_TOP    8'h2b
`define PDCB_OFF_IN_MID    8'h2c
`define PDCB_OFF_IN_LOW    8'h2d
`define PDCB_OFF_XT_TOP    8'h2e

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PDCB_RST_OUT_MID   8'h00
`define PDCB_RST_OUT_LOW   8'h31
`define PDCB_RST_FB_TOP    8'hc0
`define PDCB_RST_FB_MID    8'h00
`define PDCB_RST_FB_LOW    8'hf9
`define PDCB_RST_IN_TOP    8'h00
`define PDCB_RST_IN_MID    8'h00
`define PDCB_RST_IN_LOW    8'h09
`define PDCB_RST_XT_TOP    8'h00
`define PDCB_RST_OUT_TOP   4'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PDCB_FB_HS_MSB     7
`define PDCB_FB_HS_LSB     5
`define PDCB_FB_LS_TOP_MSB 3
`define PDCB_PD_TOP_MSB    2
// High-speed code 000 means ratio 4, so count limit is code plus 3
`define PDCB_HS_OFFSET     4'h3

`endif

// File: src/pdcb_pkg.sv
/*
  Types of the divider configuration bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pdcb_pkg;
  typedef logic [7:0] pdcb_byte_t;

  typedef enum logic [0:0] {
    PDCB_SRC_REF  = 1'b0,
    PDCB_SRC_XTAL = 1'b1
  } pdcb_src_t;
endpackage

// File: src/pdcb_divider.sv
/*
  Integer divider stage driven by an input tick enable.
  Assumes ratioMinusOne comes from the same clock domain.
*/
`timescale 1ns/100ps
module pdcb_divider #(
  parameter int WIDTH = 20
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tickIn,
  input  wire logic [WIDTH-1:0] ratioMinusOne,
  output logic                  tickOut,
  output logic                  levelOut
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH:0]   half;

  if (WIDTH < 2) begin : g_bad_width
    $error("pdcb_divider: WIDTH must be at least 2");
  end

  // Limit compare, not equality, so a ratio cut mid-count wraps at once
  assign half = ({1'b0, ratioMinusOne} + {{WIDTH{1'b0}}, 1'b1}) >> 1;

  always_comb begin
    count_d = (count_q >= ratioMinusOne) ? '0 : count_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= '0;
      tickOut  <= 1'b0;
      levelOut <= 1'b0;
    end else begin
      if (tickIn) begin
        count_q <= count_d;
      end
      tickOut  <= tickIn && (count_q >= ratioMinusOne);
      // Ratio 1 passes each input tick as a one-cycle pulse so the rate survives
      levelOut <= (ratioMinusOne == '0) ? tickIn : ({1'b0, (tickIn ? count_d : count_q)} < half);
    end
  end
endmodule

// File: src/pll_divider_config_bank.sv
/*
  Divider configuration bank: byte registers from the serial host port and the
  output, feedback and input predivider chains they steer.
  Assumes the serial front end delivers one-cycle byte strobes on clk and that
  refClockIn and crystalClockIn are slower than half the clk rate.
*/
`timescale 1ns/100ps
`include "pdcb_params.svh"
module pll_divider_config_bank (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic [7:0]      regRdData,
  input  wire logic [3:0] outputDividerTop,
  input  wire logic       outputDividerTopWrEn,
  input  wire logic [2:0] outputHsDividerCode,
  input  wire logic [15:0] crystalPredivLow,
  input  wire logic       freeRunMode,
  input  wire logic       refClockIn,
  input  wire logic       crystalClockIn,
  output logic            outputClock,
  output logic            phaseDetectorRef,
  output logic            phaseDetectorFeedback,
  output logic            fbLsCodeFixed
);
  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  pdcb_pkg::pdcb_byte_t outMid_q, outLow_q, fbTop_q, fbMid_q, fbLow_q;
  pdcb_pkg::pdcb_byte_t inTop_q, inMid_q, inLow_q, xtTop_q;
  logic [3:0]           outTop_q;

  function automatic logic wrHit(input logic we, input logic [7:0] a, input logic [7:0] off);
    return we && (a == off);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outMid_q <= `PDCB_RST_OUT_MID;
      outLow_q <= `PDCB_RST_OUT_LOW;
      outTop_q <= `PDCB_RST_OUT_TOP;
    end else begin
      // Odd-or-zero is the host's duty; stored as written
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_OUT_MID)) begin
        outMid_q <= regWrData;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_OUT_LOW)) begin
        outLow_q <= regWrData;
      end
      if (outputDividerTopWrEn) begin
        outTop_q <= outputDividerTop;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbTop_q <= `PDCB_RST_FB_TOP;
      fbMid_q <= `PDCB_RST_FB_MID;
      fbLow_q <= `PDCB_RST_FB_LOW;
    end else begin
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_FB_TOP)) begin
        fbTop_q <= regWrData & 8'hef;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_FB_MID)) begin
        fbMid_q <= regWrData;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_FB_LOW)) begin
        fbLow_q <= regWrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inTop_q <= `PDCB_RST_IN_TOP;
      inMid_q <= `PDCB_RST_IN_MID;
      inLow_q <= `PDCB_RST_IN_LOW;
      xtTop_q <= `PDCB_RST_XT_TOP;
    end else begin
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_IN_TOP)) begin
        inTop_q <= regWrData & 8'h07;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_IN_MID)) begin
        inMid_q <= regWrData;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_IN_LOW)) begin
        inLow_q <= regWrData;
      end
      if (wrHit(regWrEn, regAddr, `PDCB_OFF_XT_TOP)) begin
        xtTop_q <= regWrData & 8'h07;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `PDCB_OFF_OUT_MID: regRdData <= outMid_q;
        `PDCB_OFF_OUT_LOW: regRdData <= outLow_q;
        `PDCB_OFF_FB_TOP:  regRdData <= fbTop_q;
        `PDCB_OFF_FB_MID:  regRdData <= fbMid_q;
        `PDCB_OFF_FB_LOW:  regRdData <= fbLow_q;
        `PDCB_OFF_IN_TOP:  regRdData <= inTop_q;
        `PDCB_OFF_IN_MID:  regRdData <= inMid_q;
        `PDCB_OFF_IN_LOW:  regRdData <= inLow_q;
        `PDCB_OFF_XT_TOP:  regRdData <= xtTop_q;
        default:           regRdData <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge ticks
  // --------------------------------------------------------------------------
  logic [2:0] refSync_q, xtSync_q;
  logic       refTick, xtTick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refSync_q <= 3'h0;
      xtSync_q  <= 3'h0;
    end else begin
      refSync_q <= {refSync_q[1:0], refClockIn};
      xtSync_q  <= {xtSync_q[1:0], crystalClockIn};
    end
  end

  // Only stages 1 and 2 are looked at; stage 0 is metastability guard
  assign refTick = refSync_q[1] && !refSync_q[2];
  assign xtTick  = xtSync_q[1] && !xtSync_q[2];

  // --------------------------------------------------------------------------
  // Divider chains
  // --------------------------------------------------------------------------
  logic [3:0]  outHsRm1, fbHsRm1;
  logic [19:0] outLsRm1, fbLsRm1, fbLsField;
  logic [18:0] inRm1, xtRm1;
  logic        outHsTick, outLsTick, fbHsTick, fbLsTick, fbLsLevel, refLevel, xtLevel;

  assign outHsRm1  = {1'b0, outputHsDividerCode} + `PDCB_HS_OFFSET;
  assign outLsRm1  = {outTop_q, outMid_q, outLow_q};
  assign fbHsRm1   = {1'b0, fbTop_q[`PDCB_FB_HS_MSB:`PDCB_FB_HS_LSB]} + `PDCB_HS_OFFSET;
  assign fbLsField = {fbTop_q[`PDCB_FB_LS_TOP_MSB:0], fbMid_q, fbLow_q};
  // Even code would mean an odd ratio; bit 0 forced so the loop stays legal
  assign fbLsRm1   = {fbLsField[19:1], 1'b1};
  assign inRm1     = {inTop_q[`PDCB_PD_TOP_MSB:0], inMid_q, inLow_q};
  assign xtRm1     = {xtTop_q[`PDCB_PD_TOP_MSB:0], crystalPredivLow};

  pdcb_divider #(.WIDTH(4)) u_outHs (
    .clk(clk), .rst_n(rst_n), .tickIn(1'b1), .ratioMinusOne(outHsRm1),
    .tickOut(outHsTick), .levelOut()
  );
  pdcb_divider #(.WIDTH(20)) u_outLs (
    .clk(clk), .rst_n(rst_n), .tickIn(outHsTick), .ratioMinusOne(outLsRm1),
    .tickOut(outLsTick), .levelOut(outputClock)
  );
  pdcb_divider #(.WIDTH(4)) u_fbHs (
    .clk(clk), .rst_n(rst_n), .tickIn(1'b1), .ratioMinusOne(fbHsRm1),
    .tickOut(fbHsTick), .levelOut()
  );
  pdcb_divider #(.WIDTH(20)) u_fbLs (
    .clk(clk), .rst_n(rst_n), .tickIn(fbHsTick), .ratioMinusOne(fbLsRm1),
    .tickOut(fbLsTick), .levelOut(fbLsLevel)
  );
  pdcb_divider #(.WIDTH(19)) u_inPd (
    .clk(clk), .rst_n(rst_n), .tickIn(refTick), .ratioMinusOne(inRm1),
    .tickOut(), .levelOut(refLevel)
  );
  pdcb_divider #(.WIDTH(19)) u_xtPd (
    .clk(clk), .rst_n(rst_n), .tickIn(xtTick), .ratioMinusOne(xtRm1),
    .tickOut(), .levelOut(xtLevel)
  );

  // --------------------------------------------------------------------------
  // Phase detector feeds and status
  // --------------------------------------------------------------------------
  pdcb_pkg::pdcb_src_t refSel;
  assign refSel = freeRunMode ? pdcb_pkg::PDCB_SRC_XTAL : pdcb_pkg::PDCB_SRC_REF;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseDetectorRef      <= 1'b0;
      phaseDetectorFeedback <= 1'b0;
      fbLsCodeFixed         <= 1'b0;
    end else begin
      phaseDetectorRef      <= (refSel == pdcb_pkg::PDCB_SRC_XTAL) ? xtLevel : refLevel;
      phaseDetectorFeedback <= fbLsLevel;
      fbLsCodeFixed         <= !fbLsField[0];
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [3:0] fbHsGap_q;
  logic       fbHsCodeMoved_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbHsGap_q       <= 4'h0;
      fbHsCodeMoved_q <= 1'b1;
    end else if (fbHsTick) begin
      fbHsGap_q       <= 4'h1;
      fbHsCodeMoved_q <= 1'b0;
    end else begin
      fbHsGap_q       <= fbHsGap_q + 4'h1;
      fbHsCodeMoved_q <= fbHsCodeMoved_q || (fbHsRm1 != $past(fbHsRm1));
    end
  end

  // High-speed ticks per low-speed period, kept as parity; odd count is an odd ratio
  logic fbLsPar_q;
  logic fbLsMoved_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbLsPar_q   <= 1'b0;
      fbLsMoved_q <= 1'b1;
    end else if (fbLsTick) begin
      fbLsPar_q   <= fbHsTick;
      fbLsMoved_q <= (fbLsRm1 != $past(fbLsRm1));
    end else begin
      fbLsPar_q   <= fbLsPar_q ^ fbHsTick;
      fbLsMoved_q <= fbLsMoved_q || (fbLsRm1 != $past(fbLsRm1));
    end
  end

  sequence wrFbMid_s;
    regWrEn && !regRdEn && (regAddr == `PDCB_OFF_FB_MID);
  endsequence
  sequence rdFbMid_s;
    regRdEn && !regWrEn && (regAddr == `PDCB_OFF_FB_MID);
  endsequence

  resetDefaults_a: assert property (@(posedge clk) $rose(rst_n) |->
    fbLow_q == 8'hf9 && fbTop_q == 8'hc0 && outLow_q == 8'h31 && inLow_q == 8'h09)
    else $error("divider defaults wrong after reset");
  fbHsPeriod_a: assert property (@(posedge clk) disable iff (!rst_n)
    fbHsTick && !fbHsCodeMoved_q && $stable(fbTop_q[7:5]) && fbHsGap_q != 4'h0 |->
    fbHsGap_q == {1'b0, fbTop_q[7:5]} + 4'h4)
    else $error("feedback high-speed period mismatch");
  fbLsEven_a: assert property (@(posedge clk) disable iff (!rst_n)
    fbLsTick && !fbLsMoved_q |-> !fbLsPar_q)
    else $error("feedback low-speed ratio not even");
  fbFixFlag_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 fbLsCodeFixed == !$past(fbLsField[0]))
    else $error("feedback code fix flag wrong");
  outChain_a: assert property (@(posedge clk) disable iff (!rst_n)
    outLsTick |-> $past(outHsTick))
    else $error("output low-speed tick without high-speed tick");
  refEdge_a: assert property (@(posedge clk) disable iff (!rst_n)
    refTick && $past(rst_n, 3) |-> $past(refClockIn, 2) && !$past(refClockIn, 3))
    else $error("reference tick not from synchronised edge");
  srcSelect_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 phaseDetectorRef == ($past(freeRunMode) ? $past(xtLevel) : $past(refLevel)))
    else $error("phase detector reference source wrong");
  reservedZero_a: assert property (@(posedge clk) disable iff (!rst_n)
    regRdEn && (regAddr == `PDCB_OFF_IN_TOP || regAddr == `PDCB_OFF_XT_TOP) |=>
    regRdData[7:3] == 5'h00)
    else $error("reserved bits read non-zero");
  readBack_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrFbMid_s ##1 !regWrEn ##1 rdFbMid_s |=> regRdData == $past(regWrData, 3))
    else $error("feedback mid byte read-back mismatch");
  outField_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrHit(regWrEn, regAddr, `PDCB_OFF_OUT_LOW) |=> outLsRm1[7:0] == $past(regWrData))
    else $error("output divider low byte not applied");
endmodule

// File: testbench/pdcb_host_model.sv
/*
  Host model on the byte register port of the divider bank.
  Assumes clk is the bank clock; requests change at the falling edge.
*/
`timescale 1ns/100ps
module pdcb_host_model (
  input  wire logic       clk,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    // Released lines carry garbage, never the last value
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clk);
    d = regRdData;
  endtask

  // Output divider value kept odd or zero
  task automatic progOut(input logic [15:0] v);
    wr(8'h20, v[15:8]);
    wr(8'h21, (v == 16'h0000) ? 8'h00 : (v[7:0] | 8'h01));
  endtask

  // Feedback code kept odd unless a refusal is wanted
  task automatic progFb(input logic [2:0] hs, input logic [19:0] c, input logic allowEven);
    logic [19:0] k;
    k = allowEven ? c : (c | 20'h00001);
    wr(8'h28, {hs, 1'b0, k[19:16]});
    wr(8'h29, k[15:8]);
    wr(8'h2a, k[7:0]);
  endtask
endmodule

// File: testbench/pll_divider_config_bank_tb.sv
/*
  Self-checking bench of the divider configuration bank.
  Assumes the host model file is compiled first.
*/
`timescale 1ns/100ps
module pll_divider_config_bank_tb;
  logic        clk, rst_n, outputDividerTopWrEn, freeRunMode, refClockIn, crystalClockIn;
  logic [3:0]  outputDividerTop;
  logic [2:0]  outputHsDividerCode;
  logic [15:0] crystalPredivLow;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic        regWrEn, regRdEn, outputClock, phaseDetectorRef, phaseDetectorFeedback;
  logic        fbLsCodeFixed;
  int          mismatches, nCompared, refCnt, xtCnt;
  logic [7:0]  addrs [9] = '{8'h20, 8'h21, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
  logic [7:0]  rstv  [9] = '{8'h00, 8'h31, 8'hc0, 8'h00, 8'hf9, 8'h00, 8'h00, 8'h09, 8'h00};
  logic [7:0]  wmask [9] = '{8'hff, 8'hff, 8'hef, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'h07};

  // ---------------------------------------------------------------------------
  // Clocks and pins
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Ref period 8 cycles, crystal 6, so the two paths are told apart
  always @(negedge clk) begin
    refCnt <= (refCnt == 3) ? 0 : refCnt + 1;
    xtCnt <= (xtCnt == 2) ? 0 : xtCnt + 1;
    if (refCnt == 3) refClockIn <= ~refClockIn;
    if (xtCnt == 2) crystalClockIn <= ~crystalClockIn;
  end

  pll_divider_config_bank DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .outputDividerTop(outputDividerTop), .outputDividerTopWrEn(outputDividerTopWrEn),
    .outputHsDividerCode(outputHsDividerCode), .crystalPredivLow(crystalPredivLow),
    .freeRunMode(freeRunMode), .refClockIn(refClockIn), .crystalClockIn(crystalClockIn),
    .outputClock(outputClock), .phaseDetectorRef(phaseDetectorRef),
    .phaseDetectorFeedback(phaseDetectorFeedback), .fbLsCodeFixed(fbLsCodeFixed));

  pdcb_host_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic reportAndStop();
    $display("Compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return outputClock;
      1: return phaseDetectorRef;
      default: return phaseDetectorFeedback;
    endcase
  endfunction

  // Interval between third and second rise; earlier ones may be partial
  task automatic period(input int w, input int exp, input string nm);
    int   n;
    int   k;
    logic prev;
    n = 0;
    k = 0;
    prev = pick(w);
    while (k < 3) begin
      @(negedge clk);
      n++;
      if (pick(w) === 1'b1 && prev !== 1'b1) begin
        k++;
        if (k < 3) n = 0;
      end
      prev = pick(w);
      if (n > 5000) begin
        k = 3;
        n = -1;
      end
    end
    check(nm, n, exp);
    if (n < 0) reportAndStop();
  endtask

  task automatic doReset();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic testResetValues();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      host.rd(addrs[i], d);
      check("reset value", d, rstv[i]);
    end
    host.rd(8'h30, d);
    check("unmapped read", d, 8'h00);
  endtask

  task automatic testReadBack();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      host.wr(addrs[i], 8'hff);
      host.rd(addrs[i], d);
      check("read back", d, wmask[i]);
    end
  endtask

  task automatic testFbHs();
    for (int h = 0; h < 8; h++) begin
      host.progFb(3'(h), 20'h00001, 1'b0);
      period(2, (h + 4) * 2, "feedback period");
    end
    host.progFb(3'h0, 20'h00101, 1'b0);
    period(2, 258 * 4, "feedback mid byte");
  endtask

  task automatic testFbEven();
    logic [7:0] d;
    host.progFb(3'h0, 20'h00002, 1'b1);
    repeat (2) @(negedge clk);
    check("even code flag", fbLsCodeFixed, 1'b1);
    host.rd(8'h2a, d);
    check("even code read back", d, 8'h02);
    period(2, 16, "forced even ratio");
    host.progFb(3'h0, 20'h00003, 1'b0);
    repeat (2) @(negedge clk);
    check("odd code flag", fbLsCodeFixed, 1'b0);
  endtask

  task automatic testOutput();
    outputHsDividerCode = 3'h3;
    host.progOut(16'h0003);
    period(0, 28, "output period unstrobed top");
    outputDividerTop = 4'h0;
    outputDividerTopWrEn = 1'b1;
    @(negedge clk);
    outputDividerTopWrEn = 1'b0;
    outputHsDividerCode = 3'h7;
    host.progOut(16'h0001);
    period(0, 22, "output period");
  endtask

  task automatic testRefXtal();
    freeRunMode = 1'b0;
    host.wr(8'h2b, 8'h00);
    host.wr(8'h2c, 8'h00);
    host.wr(8'h2d, 8'h03);
    period(1, 32, "ref predivider");
    host.wr(8'h2d, 8'h00);
    period(1, 8, "ref predivider one");
    freeRunMode = 1'b1;
    crystalPredivLow = 16'h0001;
    host.wr(8'h2e, 8'h00);
    period(1, 12, "crystal predivider");
    crystalPredivLow = 16'h0002;
    period(1, 18, "crystal predivider three");
  endtask

  initial begin
    rst_n = 1'b0;
    mismatches = 0;
    nCompared = 0;
    refCnt = 0;
    xtCnt = 0;
    refClockIn = 1'b0;
    crystalClockIn = 1'b0;
    outputDividerTop = 4'h5;
    outputDividerTopWrEn = 1'b0;
    outputHsDividerCode = 3'h0;
    crystalPredivLow = 16'h0000;
    freeRunMode = 1'b0;
    doReset();
    testResetValues();
    testReadBack();
    testFbHs();
    testFbEven();
    testOutput();
    testRefXtal();
    doReset();
    testResetValues();
    reportAndStop();
  end
endmodule
